// [video_encoder_mode_timing_controls.sv]
// Mode registers 7 to 9 and timing registers 0 and 1 of the video encoder, with the
// two-wire serial slave that reaches them and the small steering logic they drive.
// Assumes scl and sda come from pins (open-drain, resolved outside) and that the
// luma filter and oversampling selects arrive from other registers on core_clk.
`timescale 1ns/1ns
module video_encoder_mode_timing_controls
  import video_encoder_mode_timing_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDR = 7'h2a,  // Arbitrary value.
  parameter int DATA_W = 10
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Two-wire serial pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Settings held in other registers, same clock
  input wire logic [2:0] luma_filter_sel,
  input wire logic oversample_4x_sel,
  input wire logic field_start,
  // Sync sources and the shared multifunction pin
  input wire logic csync_src,
  input wire logic hsync_src,
  input wire logic clamp_src,
  input wire logic vsync_aux_src,
  input wire logic shared_pin_i,
  output logic sync_out_pin,
  output logic shared_pin_o,
  output logic shared_pin_oe,
  output logic teletext_in,
  // Delay paths
  input wire logic [DATA_W-1:0] luma_in,
  input wire logic [DATA_W-1:0] chroma_in,
  output logic [DATA_W-1:0] luma_out,
  output logic [DATA_W-1:0] chroma_out,
  // Processing controls
  output logic color_ctrl_en,
  output logic luma_clip_en,
  output logic hue_adj_en,
  output logic brightness_en,
  output logic sharpness_active,
  output logic prog_scan_en,
  output port_mode_type port_mode,
  output logic noise_reduce_en,
  output logic gamma_en,
  output logic gamma_curve_sel,
  output logic double_buf_active,
  output luma_floor_type luma_floor,
  output logic black_burst_luma_dac_en,
  output logic black_burst_y_dac_en,
  // Timing controls
  output logic master_slave_sel,
  output logic [1:0] timing_mode_sel,
  output logic blank_in_ctrl,
  output logic timing_counter_reset,
  output logic [1:0] hsync_width,
  output logic [1:0] hsync_vsync_delay,
  output logic [1:0] vsync_width,
  output logic [1:0] hsync_edge_pos,
  output logic [1:0] hsync_pixel_adjust
);

  // Pin synchronisers: three stages, a change counts when stages two and three agree.
  logic [2:0] scl_sync_q, sda_sync_q;
  logic scl_f_q, sda_f_q, scl_f_d, sda_f_d;

  always_comb begin
    scl_f_d = (scl_sync_q[1] == scl_sync_q[2]) ? scl_sync_q[2] : scl_f_q;
    sda_f_d = (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2] : sda_f_q;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end else if (ce) begin
      scl_sync_q <= {scl_sync_q[1:0], scl_i};
      sda_sync_q <= {sda_sync_q[1:0], sda_i};
      scl_f_q <= scl_f_d;
      sda_f_q <= sda_f_d;
    end
  end

  wire scl_rise = scl_f_d & ~scl_f_q;
  wire scl_fall = ~scl_f_d & scl_f_q;
  wire start_cond = scl_f_q & scl_f_d & sda_f_q & ~sda_f_d;
  wire stop_cond = scl_f_q & scl_f_d & ~sda_f_q & sda_f_d;

  // Serial slave and register file.
  serial_state_type state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [4:0] ptr_q, ptr_d;
  logic rw_q, rw_d, nack_q, nack_d, drive_low_q, drive_low_d;
  logic [7:0] regs_q [REG_COUNT];
  logic [7:0] regs_d [REG_COUNT];
  logic [7:0] rd_byte;
  logic [2:0] idx;
  logic mapped;

  always_comb begin
    idx = 3'(ptr_q - PIC_ADJ_OFFSET);
    mapped = (ptr_q >= PIC_ADJ_OFFSET) && (ptr_q <= SYNC_SHAPE_OFFSET);
    rd_byte = mapped ? regs_q[idx] : 8'h00;
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    ptr_d = ptr_q;
    rw_d = rw_q;
    nack_d = nack_q;
    drive_low_d = drive_low_q;
    regs_d = regs_q;
    if (start_cond) begin
      state_d = SER_ADDR;
      cnt_d = 4'h0;
      drive_low_d = 1'b0;
    end else if (stop_cond) begin
      state_d = SER_IDLE;
      drive_low_d = 1'b0;
    end else if (scl_rise) begin
      unique case (state_q)
        SER_ADDR, SER_SUB, SER_WDATA: begin
          shift_d = {shift_q[6:0], sda_f_q};
          cnt_d = cnt_q + 4'h1;
        end
        SER_RDATA_ACK: nack_d = sda_f_q;
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (state_q)
        SER_ADDR: if (cnt_q == 4'h8) begin
          if (shift_q[7:1] == DEVICE_ADDR) begin
            state_d = SER_ADDR_ACK;
            rw_d = shift_q[0];
            drive_low_d = 1'b1;
          end else begin
            state_d = SER_IDLE;
          end
        end
        SER_SUB, SER_WDATA: if (cnt_q == 4'h8) begin
          state_d = (state_q == SER_SUB) ? SER_SUB_ACK : SER_WDATA_ACK;
          drive_low_d = 1'b1;
          if (state_q == SER_SUB) begin
            ptr_d = shift_q[4:0];
          end else if (mapped) begin
            regs_d[idx] = shift_q;
          end
        end
        SER_ADDR_ACK, SER_RDATA_ACK: begin
          if (state_q == SER_RDATA_ACK && nack_q) begin
            state_d = SER_IDLE;
            drive_low_d = 1'b0;
          end else if (rw_q) begin
            state_d = SER_RDATA;
            shift_d = {rd_byte[6:0], 1'b0};
            drive_low_d = ~rd_byte[7];
            cnt_d = 4'h1;
          end else begin
            state_d = SER_SUB;
            drive_low_d = 1'b0;
            cnt_d = 4'h0;
          end
        end
        SER_SUB_ACK, SER_WDATA_ACK: begin
          state_d = SER_WDATA;
          drive_low_d = 1'b0;
          cnt_d = 4'h0;
          if (state_q == SER_WDATA_ACK) begin
            ptr_d = ptr_q + 5'h01;
          end
        end
        SER_RDATA: begin
          if (cnt_q == 4'h8) begin
            state_d = SER_RDATA_ACK;
            drive_low_d = 1'b0;
            ptr_d = ptr_q + 5'h01;
          end else begin
            drive_low_d = ~shift_q[7];
            shift_d = {shift_q[6:0], 1'b0};
            cnt_d = cnt_q + 4'h1;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= SER_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 5'h00;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      drive_low_q <= 1'b0;
      regs_q[0] <= PIC_ADJ_RESET;
      regs_q[1] <= IN_FMT_RESET;
      regs_q[2] <= LIMITER_RESET;
      regs_q[3] <= TIMING_MODE_RESET;
      regs_q[4] <= SYNC_SHAPE_RESET;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      ptr_q <= ptr_d;
      rw_q <= rw_d;
      nack_q <= nack_d;
      drive_low_q <= drive_low_d;
      regs_q <= regs_d;
    end
  end

  // Open drain: the pin is only ever pulled low.
  assign sda_o = 1'b0;
  assign sda_oe = drive_low_q;

  // Plain register fields.
  wire [7:0] pic = regs_q[0];
  wire [7:0] fmt = regs_q[1];
  wire [7:0] lim = regs_q[2];
  wire [7:0] tmc = regs_q[3];
  wire [7:0] shp = regs_q[4];
  assign color_ctrl_en = pic[COLOR_CTRL_EN_BIT];
  assign luma_clip_en = pic[LUMA_CLIP_EN_BIT];
  assign hue_adj_en = pic[HUE_ADJ_EN_BIT];
  assign brightness_en = pic[BRIGHTNESS_EN_BIT];
  assign prog_scan_en = fmt[PROG_SCAN_EN_BIT];
  assign noise_reduce_en = fmt[NOISE_REDUCE_EN_BIT];
  assign gamma_en = fmt[GAMMA_EN_BIT];
  assign black_burst_luma_dac_en = lim[BB_LUMA_DAC_EN_BIT];
  assign black_burst_y_dac_en = lim[BB_Y_DAC_EN_BIT];
  assign master_slave_sel = tmc[MASTER_SLAVE_BIT];
  assign timing_mode_sel = tmc[TIMING_MODE_LSB +: 2];
  assign blank_in_ctrl = tmc[BLANK_IN_CTRL_BIT];
  assign hsync_width = shp[HSYNC_WIDTH_LSB +: 2];
  assign hsync_vsync_delay = shp[HV_DELAY_LSB +: 2];
  assign hsync_pixel_adjust = shp[PIXEL_ADJUST_LSB +: 2];

  // Derived steering, registered so every output leaves a flip-flop.
  logic sharp_q, sharp_d, sync_q, sync_d, pin_o_q, pin_o_d, pin_oe_q, pin_oe_d;
  logic ttx_q, ttx_d, curve_q, curve_d, dbuf_q, dbuf_d, arm_q, arm_d, trst_q, trst_d;
  logic tbit_q;
  port_mode_type port_q, port_d;
  luma_floor_type floor_q, floor_d;
  logic [1:0] vw_q, vw_d, he_q, he_d;

  always_comb begin
    sharp_d = pic[SHARPNESS_EN_BIT] && (luma_filter_sel == LUMA_FILTER_EXTENDED);
    sync_d = pic[SYNC_OUT_SEL_BIT] ? csync_src : hsync_src;
    pin_oe_d = pic[SHARED_PIN_DIR_BIT];
    pin_o_d = pic[SHARED_PIN_FUNC_SEL_BIT] ? clamp_src : vsync_aux_src;
    ttx_d = pic[SHARED_PIN_DIR_BIT] ? 1'b0 : shared_pin_i;
    unique case ({fmt[WIDE_PORT_SEL_BIT], fmt[TEN_BIT_PORT_SEL_BIT]})
      2'b00: port_d = PORT_8;
      2'b01: port_d = PORT_10;
      2'b10: port_d = PORT_16;
      2'b11: port_d = PORT_20;
    endcase
    dbuf_d = fmt[DOUBLE_BUF_EN_BIT] && !tmc[MASTER_SLAVE_BIT];
    curve_d = (!dbuf_q || field_start) ? fmt[GAMMA_CURVE_SEL_BIT] : curve_q;
    if (oversample_4x_sel && lim[UNDERSHOOT_LSB +: 2] != 2'h0) begin
      unique case (lim[UNDERSHOOT_LSB +: 2])
        2'h1: floor_d = FLOOR_MINUS_1P5;
        2'h2: floor_d = FLOOR_MINUS_6;
        default: floor_d = FLOOR_MINUS_11;
      endcase
    end else begin
      floor_d = tmc[MIN_LUMA_BIT] ? FLOOR_MINUS_7 : FLOOR_SYNC_BOTTOM;
    end
    arm_d = arm_q;
    trst_d = 1'b0;
    if (!tbit_q && tmc[TIMING_RESET_BIT]) begin
      arm_d = 1'b1;
    end else if (tbit_q && !tmc[TIMING_RESET_BIT] && arm_q) begin
      arm_d = 1'b0;
      trst_d = 1'b1;
    end
    vw_d = (timing_mode_sel == TIMING_MODE_2) ? shp[VSYNC_FIELD_LSB +: 2] : 2'h0;
    he_d = (timing_mode_sel == TIMING_MODE_1) ? shp[VSYNC_FIELD_LSB +: 2] : 2'h0;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sharp_q <= 1'b0;
      sync_q <= 1'b0;
      pin_o_q <= 1'b0;
      pin_oe_q <= 1'b0;
      ttx_q <= 1'b0;
      port_q <= PORT_8;
      dbuf_q <= 1'b0;
      curve_q <= 1'b0;
      floor_q <= FLOOR_SYNC_BOTTOM;
      tbit_q <= 1'b0;
      arm_q <= 1'b0;
      trst_q <= 1'b0;
      vw_q <= 2'h0;
      he_q <= 2'h0;
    end else if (ce) begin
      sharp_q <= sharp_d;
      sync_q <= sync_d;
      pin_o_q <= pin_o_d;
      pin_oe_q <= pin_oe_d;
      ttx_q <= ttx_d;
      port_q <= port_d;
      dbuf_q <= dbuf_d;
      curve_q <= curve_d;
      floor_q <= floor_d;
      tbit_q <= tmc[TIMING_RESET_BIT];
      arm_q <= arm_d;
      trst_q <= trst_d;
      vw_q <= vw_d;
      he_q <= he_d;
    end
  end

  assign sharpness_active = sharp_q;
  assign sync_out_pin = sync_q;
  assign shared_pin_o = pin_o_q;
  assign shared_pin_oe = pin_oe_q;
  assign teletext_in = ttx_q;
  assign port_mode = port_q;
  assign double_buf_active = dbuf_q;
  assign gamma_curve_sel = curve_q;
  assign luma_floor = floor_q;
  assign timing_counter_reset = trst_q;
  assign vsync_width = vw_q;
  assign hsync_edge_pos = he_q;

  // Delay lines: tap k holds the input from k+1 cycles ago.
  logic [DATA_W-1:0] luma_tap_q [DELAY_DEPTH];
  logic [DATA_W-1:0] chroma_tap_q [DELAY_DEPTH];
  logic [DATA_W-1:0] luma_out_q, luma_out_d, chroma_out_q, chroma_out_d;
  logic [2:0] luma_sel, chroma_sel;

  genvar g;
  for (g = 0; g < DELAY_DEPTH; g++) begin : g_tap
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        luma_tap_q[g] <= '0;
        chroma_tap_q[g] <= '0;
      end else if (ce) begin
        luma_tap_q[g] <= (g == 0) ? luma_in : luma_tap_q[(g == 0) ? 0 : g - 1];
        chroma_tap_q[g] <= (g == 0) ? chroma_in : chroma_tap_q[(g == 0) ? 0 : g - 1];
      end
    end
  end

  always_comb begin
    // luma delay two cycles per step
    luma_sel = 3'(tmc[LUMA_DELAY_LSB +: 2] * LUMA_DELAY_STEP);
    luma_out_d = (luma_sel == 3'h0) ? luma_in : luma_tap_q[luma_sel - 3'h1];
    chroma_sel = lim[CHROMA_DELAY_LSB +: 3];
    chroma_out_d = chroma_tap_q[chroma_sel];
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      luma_out_q <= '0;
      chroma_out_q <= '0;
    end else if (ce) begin
      luma_out_q <= luma_out_d;
      chroma_out_q <= chroma_out_d;
    end
  end

  assign luma_out = luma_out_q;
  assign chroma_out = chroma_out_q;

endmodule : video_encoder_mode_timing_controls

// [video_encoder_mode_timing_pkg.sv]
// Constants for the mode and timing register bank of the video encoder.
// Assumes one 27 MHz pixel clock domain and a two-wire serial host.
package video_encoder_mode_timing_pkg;

  // Register subaddresses on the serial interface.
  localparam logic [4:0] PIC_ADJ_OFFSET = 5'h07;
  localparam logic [4:0] IN_FMT_OFFSET = 5'h08;
  localparam logic [4:0] LIMITER_OFFSET = 5'h09;
  localparam logic [4:0] TIMING_MODE_OFFSET = 5'h0a;
  localparam logic [4:0] SYNC_SHAPE_OFFSET = 5'h0b;
  localparam int REG_COUNT = 5;

  // Values after reset.
  localparam logic [7:0] PIC_ADJ_RESET = 8'h00;
  localparam logic [7:0] IN_FMT_RESET = 8'h00;
  localparam logic [7:0] LIMITER_RESET = 8'h00;
  localparam logic [7:0] TIMING_MODE_RESET = 8'h00;
  localparam logic [7:0] SYNC_SHAPE_RESET = 8'h00;

  // Bit positions of the picture adjust and pin mode register.
  localparam int COLOR_CTRL_EN_BIT = 0;
  localparam int LUMA_CLIP_EN_BIT = 1;
  localparam int HUE_ADJ_EN_BIT = 2;
  localparam int BRIGHTNESS_EN_BIT = 3;
  localparam int SHARPNESS_EN_BIT = 4;
  localparam int SYNC_OUT_SEL_BIT = 5;
  localparam int SHARED_PIN_DIR_BIT = 6;
  localparam int SHARED_PIN_FUNC_SEL_BIT = 7;
  // Bit positions of the input format and processing register.
  localparam int PROG_SCAN_EN_BIT = 0;
  localparam int DOUBLE_BUF_EN_BIT = 2;
  localparam int WIDE_PORT_SEL_BIT = 3;
  localparam int TEN_BIT_PORT_SEL_BIT = 4;
  localparam int NOISE_REDUCE_EN_BIT = 5;
  localparam int GAMMA_EN_BIT = 6;
  localparam int GAMMA_CURVE_SEL_BIT = 7;
  // Bit positions of the limiter, burst and chroma delay register.
  localparam int UNDERSHOOT_LSB = 0;
  localparam int BB_LUMA_DAC_EN_BIT = 2;
  localparam int BB_Y_DAC_EN_BIT = 3;
  localparam int CHROMA_DELAY_LSB = 5;
  // Bit positions of the timing mode control register.
  localparam int MASTER_SLAVE_BIT = 0;
  localparam int TIMING_MODE_LSB = 1;
  localparam int BLANK_IN_CTRL_BIT = 3;
  localparam int LUMA_DELAY_LSB = 4;
  localparam int MIN_LUMA_BIT = 6;
  localparam int TIMING_RESET_BIT = 7;
  // Bit positions of the sync pulse shaping register.
  localparam int HSYNC_WIDTH_LSB = 0;
  localparam int HV_DELAY_LSB = 2;
  localparam int VSYNC_FIELD_LSB = 4;
  localparam int PIXEL_ADJUST_LSB = 6;

  // Encodings.
  localparam logic [2:0] LUMA_FILTER_EXTENDED = 3'h4;
  localparam logic [1:0] TIMING_MODE_1 = 2'h1;
  localparam logic [1:0] TIMING_MODE_2 = 2'h2;
  localparam logic [2:0] LUMA_DELAY_STEP = 3'h2;
  localparam int DELAY_DEPTH = 8;

  // Pixel port layouts: 8, 10, 16 and 20 bit.
  typedef enum logic [1:0] {PORT_8, PORT_10, PORT_16, PORT_20} port_mode_type;
  // Luma floor: none (sync bottom), 7 IRE below blank, or the three limiter levels.
  typedef enum logic [2:0] {
    FLOOR_SYNC_BOTTOM, FLOOR_MINUS_7, FLOOR_MINUS_1P5, FLOOR_MINUS_6, FLOOR_MINUS_11
  } luma_floor_type;

  typedef enum {
    SER_IDLE, SER_ADDR, SER_ADDR_ACK, SER_SUB, SER_SUB_ACK, SER_WDATA, SER_WDATA_ACK,
    SER_RDATA, SER_RDATA_ACK
  } serial_state_type;

endpackage : video_encoder_mode_timing_pkg

// [mode_timing_checker_asserts.sv]
// Concurrent checks on the outputs of the mode and timing register bank.
// Assumes it is bound to the top module; checks pause while the clock enable is low.
`timescale 1ns/1ns
module mode_timing_checker
  import video_encoder_mode_timing_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Watched inputs
  input wire logic field_start,
  input wire logic [2:0] luma_filter_sel,
  input wire logic oversample_4x_sel,
  input wire logic shared_pin_i,
  // Watched outputs
  input wire logic shared_pin_oe,
  input wire logic teletext_in,
  input wire logic sharpness_active,
  input wire logic gamma_curve_sel,
  input wire logic double_buf_active,
  input wire luma_floor_type luma_floor,
  input wire logic master_slave_sel,
  input wire logic [1:0] timing_mode_sel,
  input wire logic timing_counter_reset,
  input wire logic [1:0] vsync_width,
  input wire logic [1:0] hsync_edge_pos
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst || !ce);

  a_teletext_gate: assert property (1'b1 |=> (shared_pin_oe ? !teletext_in :
    teletext_in == $past(shared_pin_i))) else $error("teletext input gating wrong");
  a_sharp_filter: assert property (luma_filter_sel != LUMA_FILTER_EXTENDED
    |=> !sharpness_active) else $error("sharpness active without extended filter");
  a_dbuf_master: assert property (master_slave_sel && $past(master_slave_sel)
    |-> !double_buf_active) else $error("double buffering active in master mode");
  // A new curve select may only land at a field start while buffering.
  a_gamma_hold: assert property (double_buf_active && $past(double_buf_active) &&
    !field_start && !$past(field_start) |-> $stable(gamma_curve_sel))
    else $error("gamma curve changed between fields");
  a_treset_single: assert property (timing_counter_reset |=> !timing_counter_reset)
    else $error("timing counter reset longer than one cycle");
  a_vsync_mode: assert property (timing_mode_sel != TIMING_MODE_2
    |=> vsync_width == 2'h0) else $error("vsync width outside timing mode 2");
  a_hedge_mode: assert property (timing_mode_sel != TIMING_MODE_1
    |=> hsync_edge_pos == 2'h0) else $error("hsync edge position outside timing mode 1");
  a_floor_plain: assert property (!oversample_4x_sel
    |=> luma_floor inside {FLOOR_SYNC_BOTTOM, FLOOR_MINUS_7})
    else $error("limiter floor used without oversampling");
endmodule : mode_timing_checker

bind video_encoder_mode_timing_controls mode_timing_checker chk_u (
  .core_clk(core_clk), .rst(rst), .ce(ce), .field_start(field_start),
  .luma_filter_sel(luma_filter_sel), .oversample_4x_sel(oversample_4x_sel),
  .shared_pin_i(shared_pin_i), .shared_pin_oe(shared_pin_oe), .teletext_in(teletext_in),
  .sharpness_active(sharpness_active), .gamma_curve_sel(gamma_curve_sel),
  .double_buf_active(double_buf_active), .luma_floor(luma_floor),
  .master_slave_sel(master_slave_sel), .timing_mode_sel(timing_mode_sel),
  .timing_counter_reset(timing_counter_reset), .vsync_width(vsync_width),
  .hsync_edge_pos(hsync_edge_pos)
);

// [tb_top.sv]
// Self-checking bench for the mode and timing register bank.
// Assumes the checker binds itself to the design; all inputs change on the falling edge.
`timescale 1ns/1ns
module tb_top
  import video_encoder_mode_timing_pkg::*;
;
  localparam logic [6:0] ADDR = 7'h2a;  // Arbitrary value.
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic sda_o, teletext_in;
  logic scl_m = 1'b1;
  logic sda_m = 1'b1;
  logic fs = 1'b0;
  logic os = 1'b0;
  logic [2:0] lfs = 3'h0;
  logic [9:0] cnt = 10'h000;
  logic [7:0] pat [2] = '{8'h5a, 8'ha5};
  int bad_count = 0;
  int num_checks = 0;
  int tr_cnt = 0;
  logic sda_oe, sync_out_pin, shared_pin_o, shared_pin_oe, color_ctrl_en, luma_clip_en;
  logic hue_adj_en, brightness_en, sharpness_active, prog_scan_en, noise_reduce_en;
  logic gamma_en, gamma_curve_sel, double_buf_active, black_burst_luma_dac_en;
  logic black_burst_y_dac_en, master_slave_sel, blank_in_ctrl, timing_counter_reset;
  logic [1:0] timing_mode_sel, hsync_width, hsync_vsync_delay, vsync_width;
  logic [1:0] hsync_edge_pos, hsync_pixel_adjust;
  logic [9:0] luma_out, chroma_out;
  port_mode_type port_mode;
  luma_floor_type luma_floor;
  // While enabled the slave drives its output level; otherwise the bench level wins.
  wire sda_w = sda_m & (sda_oe ? sda_o : 1'b1);

  video_encoder_mode_timing_controls #(.DEVICE_ADDR(ADDR), .DATA_W(10)) dut_u (
    .core_clk(core_clk), .rst(rst), .ce(ce), .scl_i(scl_m), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .luma_filter_sel(lfs), .oversample_4x_sel(os), .field_start(fs),
    .csync_src(cnt[0]), .hsync_src(cnt[1]), .clamp_src(cnt[2]), .vsync_aux_src(cnt[3]),
    .shared_pin_i(cnt[4]), .sync_out_pin(sync_out_pin), .shared_pin_o(shared_pin_o),
    .shared_pin_oe(shared_pin_oe), .teletext_in(teletext_in),
    .luma_in(cnt), .chroma_in(~cnt),
    .luma_out(luma_out), .chroma_out(chroma_out), .color_ctrl_en(color_ctrl_en),
    .luma_clip_en(luma_clip_en), .hue_adj_en(hue_adj_en), .brightness_en(brightness_en),
    .sharpness_active(sharpness_active), .prog_scan_en(prog_scan_en),
    .port_mode(port_mode), .noise_reduce_en(noise_reduce_en), .gamma_en(gamma_en),
    .gamma_curve_sel(gamma_curve_sel), .double_buf_active(double_buf_active),
    .luma_floor(luma_floor), .black_burst_luma_dac_en(black_burst_luma_dac_en),
    .black_burst_y_dac_en(black_burst_y_dac_en), .master_slave_sel(master_slave_sel),
    .timing_mode_sel(timing_mode_sel), .blank_in_ctrl(blank_in_ctrl),
    .timing_counter_reset(timing_counter_reset), .hsync_width(hsync_width),
    .hsync_vsync_delay(hsync_vsync_delay), .vsync_width(vsync_width),
    .hsync_edge_pos(hsync_edge_pos), .hsync_pixel_adjust(hsync_pixel_adjust)
  );

  always #10 core_clk = ~core_clk;
  // A running count feeds every sync source and both data paths.
  always @(negedge core_clk) begin
    cnt <= cnt + 10'h001;
    if (timing_counter_reset === 1'b1) begin
      tr_cnt++;
    end
  end

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  task automatic wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wt

  // Data moves two cycles after the clock falls, so the slave never sees it as a start or stop.
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    wt(8);
    scl_m = 1'b1;
    wt(8);
    r = sda_w;
    scl_m = 1'b0;
    wt(2);
  endtask : bit_io

  task automatic start();
    sda_m = 1'b1;
    wt(8);
    scl_m = 1'b1;
    wt(8);
    sda_m = 1'b0;
    wt(8);
    scl_m = 1'b0;
    wt(2);
  endtask : start

  task automatic stop();
    sda_m = 1'b0;
    wt(8);
    scl_m = 1'b1;
    wt(8);
    sda_m = 1'b1;
    wt(8);
  endtask : stop

  task automatic xbyte(input logic [7:0] d, input logic m_ack, output logic [7:0] q,
                       output logic s_ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(m_ack, s_ack);
  endtask : xbyte

  task automatic reg_wr(input logic [7:0] sub, input logic [7:0] val);
    logic [7:0] b [3];
    logic [7:0] q;
    logic a;
    b = '{{ADDR, 1'b0}, sub, val};
    start();
    foreach (b[k]) begin
      xbyte(b[k], 1'b1, q, a);
      chk(a, 1'b0);
    end
    stop();
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] sub, output logic [7:0] q);
    logic a;
    start();
    xbyte({ADDR, 1'b0}, 1'b1, q, a);
    xbyte(sub, 1'b1, q, a);
    start();
    xbyte({ADDR, 1'b1}, 1'b1, q, a);
    chk(a, 1'b0);
    xbyte(8'hff, 1'b1, q, a);
    stop();
  endtask : reg_rd

  initial begin
    repeat (80000) @(posedge core_clk);
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    logic [7:0] q;
    logic [7:0] v;
    logic a;
    logic [9:0] lv;
    logic [7:0] bw [4] = '{{ADDR, 1'b0}, 8'h0a, 8'h0e, 8'h6d};
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    wt(4);
    for (int s = 7; s < 12; s++) begin
      reg_rd(s[7:0], q);
      chk(q, 8'h00);
    end
    chk(port_mode, PORT_8);
    chk(luma_floor, FLOOR_SYNC_BOTTOM);
    start();
    xbyte({ADDR ^ 7'h01, 1'b0}, 1'b1, q, a);
    chk(a, 1'b1);
    stop();
    reg_wr(8'h0c, 8'hff);
    reg_rd(8'h0c, q);
    chk(q, 8'h00);
    foreach (pat[i]) begin
      v = pat[i];
      reg_wr(8'h07, v);
      reg_rd(8'h07, q);
      chk(q, v);
      chk(color_ctrl_en, v[0]);
      chk(luma_clip_en, v[1]);
      chk(hue_adj_en, v[2]);
      chk(brightness_en, v[3]);
      chk(shared_pin_oe, v[6]);
      for (int f = 3; f < 5; f++) begin
        lfs = f[2:0];
        wt(2);
        chk(sharpness_active, v[4] && f == 4);
        chk(sync_out_pin, v[5] ? cnt[0] : cnt[1]);
        chk(shared_pin_o, v[7] ? cnt[2] : cnt[3]);
        chk(teletext_in, !v[6] && cnt[4]);
      end
    end
    for (int p = 0; p < 4; p++) begin
      reg_wr(8'h08, {p[1], p[0], p[1], p[0], p[1], 2'b00, p[0]});
      chk(port_mode, p[1:0]);
      chk(prog_scan_en, p[0]);
      chk(noise_reduce_en, p[1]);
      chk(gamma_en, p[0]);
      chk(gamma_curve_sel, p[1]);
    end
    reg_wr(8'h0a, 8'h00);
    reg_wr(8'h08, 8'h00);
    reg_wr(8'h08, 8'h04);
    reg_wr(8'h08, 8'h84);
    chk(double_buf_active, 1'b1);
    chk(gamma_curve_sel, 1'b0);
    fs = 1'b1;
    wt(1);
    fs = 1'b0;
    wt(2);
    chk(gamma_curve_sel, 1'b1);
    reg_wr(8'h0a, 8'h01);
    chk(double_buf_active, 1'b0);
    for (int m = 0; m < 2; m++) begin
      reg_wr(8'h0a, {1'b0, m[0], 6'h00});
      for (int c = 0; c < 4; c++) begin
        reg_wr(8'h09, {4'h0, c[1:0], c[1:0]});
        chk(black_burst_luma_dac_en, c[0]);
        chk(black_burst_y_dac_en, c[1]);
        for (int o = 0; o < 2; o++) begin
          os = o[0];
          wt(2);
          chk(luma_floor, (o == 1 && c != 0) ? c + 1 : m);
        end
      end
    end
    os = 1'b0;
    for (int k = 0; k < 8; k++) begin
      reg_wr(8'h09, {k[2:0], 5'h00});
      reg_wr(8'h0a, {2'b00, k[1:0], 4'h0});
      wt(1);
      chk(luma_out, cnt - 10'(2 * (k % 4)));
      chk(chroma_out, ~(cnt - 10'(k + 1)));
    end
    tr_cnt = 0;
    reg_wr(8'h0a, 8'h80);
    chk(10'(tr_cnt), 10'h000);
    reg_wr(8'h0a, 8'h00);
    chk(10'(tr_cnt), 10'h001);
    reg_wr(8'h0a, 8'h00);
    chk(10'(tr_cnt), 10'h001);
    reg_wr(8'h0b, 8'hb6);
    for (int m = 0; m < 4; m++) begin
      reg_wr(8'h0a, {4'h0, 1'b1, m[1:0], 1'b0});
      chk(timing_mode_sel, m[1:0]);
      chk(blank_in_ctrl, 1'b1);
      chk(vsync_width, m == 2 ? 3 : 0);
      chk(hsync_edge_pos, m == 1 ? 3 : 0);
    end
    chk(hsync_width, 2'h2);
    chk(hsync_vsync_delay, 2'h1);
    chk(hsync_pixel_adjust, 2'h2);
    // With the enable low the running luma path must hold still.
    ce = 1'b0;
    lv = luma_out;
    wt(4);
    chk(luma_out, lv);
    ce = 1'b1;
    wt(4);
    reg_rd(8'h0b, q);
    chk(q, 8'hb6);
    // One transfer of two data bytes lands in two registers through the pointer step.
    start();
    foreach (bw[k]) begin
      xbyte(bw[k], 1'b1, q, a);
      chk(a, 1'b0);
    end
    stop();
    chk(hsync_width, 2'h1);
    reg_rd(8'h0b, q);
    chk(q, 8'h6d);
    wrap_up();
  end
endmodule : tb_top
